// >>> pkt_start_pkg.sv
/*
 * constants, field layouts and carriers for the packet-start indicator.
 * assumes a single core clock domain; frame strobes arrive as plain levels.
 */
//
// Operation
// - fixed length is (field+1)*8 receive clocks
// - indication always drops at frame end
// - bit 3 picks fixed length or whole frame
// - bit 2 picks delimiter or first-byte trigger
// - receive indications only with bit 1 set
// - transmit indications only with bit 0 set
// - transmit start taken after the transmit FIFO
// - 10M receive delay from bits 15:11
// - 100M receive delay from bits 10:6
// - 1G receive delay from bits 5:0
// - 10M transmit delay from bits 12:8
// - 100M transmit delay from bits 7:4
// - 1G transmit delay from bits 3:0
// - control resets to 0x0034
`default_nettype none

package pkt_start_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [15:0] CTRL_ADDR     = 16'h9428;
   localparam logic [15:0] RX_DEL_ADDR   = 16'h9429;
   localparam logic [15:0] TX_DEL_ADDR   = 16'h942a;
   localparam logic [15:0] CTRL_RESET    = 16'h0034;
   localparam logic [15:0] RX_DEL_RESET  = 16'h0000;
   localparam logic [15:0] TX_DEL_RESET  = 16'h0000;
   localparam logic [15:0] CTRL_MASK     = 16'h007f;
   localparam logic [15:0] TX_DEL_MASK   = 16'h1fff;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int TICK_NS      = 8;
   localparam int CORE_CLK_PS  = 5000;
   localparam int TICK_PS      = TICK_NS * 1000;
   localparam int EIGHTHS      = 8;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SPEED_10M,
      SPEED_100M,
      SPEED_1G
   } speed_t;

   typedef struct packed {
      logic [8:0] reserved;
      logic [2:0] pulse_len_eighths_minus_one;
      logic       fixed_pulse_len_enable;
      logic       delimiter_trigger_enable;
      logic       rx_indication_enable;
      logic       tx_indication_enable;
   } ctrl_t;

   typedef struct packed {
      logic [4:0] rx_delay_10m;
      logic [4:0] rx_delay_100m;
      logic [5:0] rx_delay_1g;
   } rx_del_t;

   typedef struct packed {
      logic [2:0] reserved;
      logic [4:0] tx_delay_10m;
      logic [3:0] tx_delay_100m;
      logic [3:0] tx_delay_1g;
   } tx_del_t;

   // frame strobes for one direction
   typedef struct packed {
      logic frame;
      logic sfd;
   } frame_t;

endpackage : pkt_start_pkg

`default_nettype wire

// >>> pkt_start.sv
/*
 * packet-start indicator: one level per direction for time stamp capture.
 * assumes frame strobes from the PHY datapath (tx taken at FIFO output),
 * register port on the core clock, and the receive clock as a foreign pin.
 */
`default_nettype none

module pkt_start (
   // clock and reset
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   // register port
   input  wire logic                  reg_wr_i,
   input  wire logic [15:0]           reg_addr_i,
   input  wire logic [15:0]           reg_wdata_i,
   output logic      [15:0]           reg_rdata_o,
   // link side
   input  wire logic                  rx_clk_i,
   input  wire pkt_start_pkg::speed_t speed_i,
   input  wire pkt_start_pkg::frame_t rx_i,
   input  wire pkt_start_pkg::frame_t tx_fifo_out_i,
   // indications
   output logic                       rx_pkt_start_o,
   output logic                       tx_pkt_start_o
);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   pkt_start_pkg::ctrl_t   ctrl_q;
   pkt_start_pkg::rx_del_t rx_del_q;
   pkt_start_pkg::tx_del_t tx_del_q;

   wire logic wr_ctrl = reg_wr_i && reg_addr_i == pkt_start_pkg::CTRL_ADDR;
   wire logic wr_rx   = reg_wr_i && reg_addr_i == pkt_start_pkg::RX_DEL_ADDR;
   wire logic wr_tx   = reg_wr_i && reg_addr_i == pkt_start_pkg::TX_DEL_ADDR;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q   <= pkt_start_pkg::CTRL_RESET;
         rx_del_q <= pkt_start_pkg::RX_DEL_RESET;
         tx_del_q <= pkt_start_pkg::TX_DEL_RESET;
      end else begin
         // reserved bits dropped on write so they always read back as zero
         if (wr_ctrl) ctrl_q <= reg_wdata_i & pkt_start_pkg::CTRL_MASK;
         if (wr_rx) rx_del_q <= reg_wdata_i;
         if (wr_tx) tx_del_q <= reg_wdata_i & pkt_start_pkg::TX_DEL_MASK;
      end
   end

   wire logic [15:0] rdata_d =
      (reg_addr_i == pkt_start_pkg::CTRL_ADDR)   ? ctrl_q   :
      (reg_addr_i == pkt_start_pkg::RX_DEL_ADDR) ? rx_del_q :
      (reg_addr_i == pkt_start_pkg::TX_DEL_ADDR) ? tx_del_q : 16'h0000;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) reg_rdata_o <= 16'h0000;
      else reg_rdata_o <= rdata_d;
   end

   // ----------------------------------------
   // synchronisers: rx clock, rx strobes, tx strobes
   // ----------------------------------------
   // layout: [4] rx clock, [3:2] rx frame/sfd, [1:0] tx frame/sfd
   logic [4:0] s1_q;
   logic [4:0] s2_q;
   logic       rclk_prev_q;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q        <= 5'h00;
         s2_q        <= 5'h00;
         rclk_prev_q <= 1'b0;
      end else begin
         s1_q        <= {rx_clk_i, rx_i, tx_fifo_out_i};
         s2_q        <= s1_q;
         rclk_prev_q <= s2_q[4];
      end
   end
   // receive-clock edge drives the eighth-counting and rx delays
   wire logic rclk_rise = s2_q[4] && !rclk_prev_q;

   // ----------------------------------------
   // 8 ns tick for transmit delays
   // ----------------------------------------
   // 8 ns is no whole number of core cycles: a picosecond phase accumulator
   // spaces ticks one or two cycles apart, 8 ns on average, no drift
   logic      [13:0] tick_acc_q;
   wire logic [13:0] tick_sum   = tick_acc_q + 14'(pkt_start_pkg::CORE_CLK_PS);
   wire logic        tick       = tick_sum >= 14'(pkt_start_pkg::TICK_PS);
   wire logic [13:0] tick_acc_d = tick ? tick_sum - 14'(pkt_start_pkg::TICK_PS) : tick_sum;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) tick_acc_q <= 14'h0000;
      else tick_acc_q <= tick_acc_d;
   end
   a_tick_gap: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !tick |=> tick) else $error("8 ns tick skipped");
   a_tick_pair: assert property (@(posedge core_clk_i) disable iff (rst_i)
      tick ##1 tick |=> !tick) else $error("8 ns tick too dense");

   // ----------------------------------------
   // delay selection per speed
   // ----------------------------------------
   wire logic [5:0] rx_delay =
      (speed_i == pkt_start_pkg::SPEED_10M)  ? {1'b0, rx_del_q.rx_delay_10m} :
      (speed_i == pkt_start_pkg::SPEED_100M) ? {1'b0, rx_del_q.rx_delay_100m} :
                                               rx_del_q.rx_delay_1g;
   wire logic [5:0] tx_delay =
      (speed_i == pkt_start_pkg::SPEED_10M)  ? {1'b0, tx_del_q.tx_delay_10m} :
      (speed_i == pkt_start_pkg::SPEED_100M) ? {2'b00, tx_del_q.tx_delay_100m} :
                                               {2'b00, tx_del_q.tx_delay_1g};
   wire logic [5:0] len_eighths = 6'(ctrl_q.pulse_len_eighths_minus_one) + 6'h01;

   // ----------------------------------------
   // per-direction engines; index 0 = tx, 1 = rx
   // ----------------------------------------
   logic [1:0] ind_q;
   logic [1:0] seen_q;
   logic [1:0] pend_q;
   logic [5:0] dly_q [2];
   logic [8:0] len_q [2];

   for (genvar d = 0; d < 2; d++) begin : g_dir
      wire logic frame = s2_q[2*d+1];
      wire logic sfd   = s2_q[2*d];
      wire logic en    = d ? ctrl_q.rx_indication_enable : ctrl_q.tx_indication_enable;
      // tx strobes come from after the FIFO so FIFO fill jitter is excluded
      wire logic trig  = en && frame && !seen_q[d] &&
                         (ctrl_q.delimiter_trigger_enable ? sfd : 1'b1);
      wire logic step  = d ? rclk_rise : tick;
      wire logic [5:0] dly = d ? rx_delay : tx_delay;
      wire logic go    = pend_q[d] && dly_q[d] == 6'h00;
      wire logic expire = ctrl_q.fixed_pulse_len_enable && len_q[d] == 9'h000;

      always_ff @(posedge core_clk_i or posedge rst_i) begin
         if (rst_i) begin
            ind_q[d]  <= 1'b0;
            seen_q[d] <= 1'b0;
            pend_q[d] <= 1'b0;
            dly_q[d]  <= 6'h00;
            len_q[d]  <= 9'h000;
         // dropping the enable ends the pulse too; seen clears so the next frame re-arms
         end else if (!frame || !en) begin
            ind_q[d]  <= 1'b0;
            seen_q[d] <= 1'b0;
            pend_q[d] <= 1'b0;
         // delay latched here: a register write mid-count never stretches the wait
         end else if (trig) begin
            seen_q[d] <= 1'b1;
            pend_q[d] <= 1'b1;
            dly_q[d]  <= dly;
         end else if (go) begin
            pend_q[d] <= 1'b0;
            ind_q[d]  <= 1'b1;
            len_q[d]  <= {len_eighths, 3'b000};
         end else begin
            if (pend_q[d] && step) dly_q[d] <= dly_q[d] - 6'h01;
            if (ind_q[d] && rclk_rise && len_q[d] != 9'h000) len_q[d] <= len_q[d] - 9'h001;
            if (ind_q[d] && expire) ind_q[d] <= 1'b0;
         end
      end
   end

   always_comb begin
      tx_pkt_start_o = ind_q[0];
      rx_pkt_start_o = ind_q[1];
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // enables and frame end, both directions
   a_rx_gate_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !ctrl_q.rx_indication_enable |=> !ind_q[1]) else $error("rx indication while disabled");
   a_tx_gate_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !ctrl_q.tx_indication_enable |=> !ind_q[0]) else $error("tx indication while disabled");
   a_rx_frame_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !s2_q[3] |=> !ind_q[1]) else $error("rx indication past frame end");
   a_tx_frame_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !s2_q[1] |=> !ind_q[0]) else $error("tx indication past frame end");

   // pulse length and trigger point
   a_len_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(ind_q[1]) |-> len_q[1] == {len_eighths, 3'b000}) else $error("bad pulse length");
   a_tx_len_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(ind_q[0]) |-> len_q[0] == {len_eighths, 3'b000}) else $error("bad tx pulse length");
   a_fixed_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ind_q[1] && ctrl_q.fixed_pulse_len_enable && len_q[1] == 9'h000 && s2_q[3]
      && !$rose(ind_q[1]) |=> !ind_q[1]) else $error("fixed pulse overran");
   a_tx_fixed_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ind_q[0] && ctrl_q.fixed_pulse_len_enable && len_q[0] == 9'h000 && s2_q[1]
      && !$rose(ind_q[0]) |=> !ind_q[0]) else $error("fixed tx pulse overran");
   a_sfd_trigger: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(pend_q[1]) |-> $past(ctrl_q.delimiter_trigger_enable) ? $past(s2_q[2]) : 1'b1)
      else $error("rx trigger without delimiter");
   a_tx_sfd_trigger: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(pend_q[0]) |-> $past(ctrl_q.delimiter_trigger_enable) ? $past(s2_q[0]) : 1'b1)
      else $error("tx trigger without delimiter");

   // delays are loaded from the field of the current speed
   a_rx_dly_10m: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(pend_q[1]) && speed_i == pkt_start_pkg::SPEED_10M
      |-> dly_q[1] == {1'b0, rx_del_q.rx_delay_10m})
      else $error("rx 10m delay not loaded");
   a_rx_dly_100m: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(pend_q[1]) && speed_i == pkt_start_pkg::SPEED_100M
      |-> dly_q[1] == {1'b0, rx_del_q.rx_delay_100m})
      else $error("rx 100m delay not loaded");
   a_rx_dly_1g: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(pend_q[1]) && speed_i == pkt_start_pkg::SPEED_1G |-> dly_q[1] == rx_del_q.rx_delay_1g)
      else $error("rx 1g delay not loaded");
   a_tx_dly_10m: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(pend_q[0]) && speed_i == pkt_start_pkg::SPEED_10M
      |-> dly_q[0] == {1'b0, tx_del_q.tx_delay_10m}) else $error("tx 10m delay not loaded");
   a_tx_dly_100m: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(pend_q[0]) && speed_i == pkt_start_pkg::SPEED_100M
      |-> dly_q[0] == {2'b00, tx_del_q.tx_delay_100m})
      else $error("tx 100m delay not loaded");
   a_tx_dly_1g: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(pend_q[0]) && speed_i == pkt_start_pkg::SPEED_1G
      |-> dly_q[0] == {2'b00, tx_del_q.tx_delay_1g})
      else $error("tx 1g delay not loaded");

endmodule : pkt_start

`default_nettype wire

// >>> ts_capture.sv
/* far side: time stamp capture, measures indication rise and length.
   assumes frame pin and indication sampled on the same core clock. */
`default_nettype none
module ts_capture (
   // sampling
   input  wire logic clk_i,
   input  wire logic frame_i,
   input  wire logic ind_i,
   // measurements in core cycles from frame start
   output int        rise_o,
   output int        len_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev = 1'b0;
   int   cyc  = 0;
   // blocking on purpose: behavioural capture, read by the bench only
   always @(posedge clk_i) begin
      if (frame_i && !prev) begin
         cyc = 0;
         rise_o = -1;
         len_o = 0;
      end
      cyc = cyc + 1;
      if (ind_i && rise_o < 0)
         rise_o = cyc;
      if (ind_i)
         len_o = len_o + 1;
      prev = frame_i;
   end
endmodule : ts_capture
`default_nettype wire

// >>> pkt_start_tb_top.sv
/* bench for pkt_start: registers, both directions, all speeds.
   assumes ts_capture on each indication and a free running receive clock. */
`default_nettype none
module pkt_start_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst = 1'b1, we = 1'b0, rx_clk = 1'b0, rx_ind, tx_ind;
   logic [15:0] addr = 16'h0000, wdat = 16'h0000, rdat, lfsr = 16'h0042;
   pkt_start_pkg::speed_t spd = pkt_start_pkg::SPEED_10M;
   pkt_start_pkg::frame_t rxf = '0, txf = '0;
   int rx_rise, rx_len, tx_rise, tx_len, miscompares = 0, total_checks = 0, cycles = 0;
   always #2.5 core_clk = ~core_clk;
   // phase offset keeps link clock edges off the core clock edges; the period is 16 core cycles
   initial #3 forever #40 rx_clk = ~rx_clk;
   pkt_start uut (.core_clk_i(core_clk), .rst_i(rst), .reg_wr_i(we), .reg_addr_i(addr),
      .reg_wdata_i(wdat), .reg_rdata_o(rdat), .rx_clk_i(rx_clk), .speed_i(spd),
      .rx_i(rxf), .tx_fifo_out_i(txf), .rx_pkt_start_o(rx_ind), .tx_pkt_start_o(tx_ind));
   ts_capture rx_cap (.clk_i(core_clk), .frame_i(rxf.frame), .ind_i(rx_ind),
      .rise_o(rx_rise), .len_o(rx_len));
   ts_capture tx_cap (.clk_i(core_clk), .frame_i(txf.frame), .ind_i(tx_ind),
      .rise_o(tx_rise), .len_o(tx_len));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction : rnd
   function automatic int rx_f(logic [15:0] d, int s);
      return s == 0 ? d[15:11] : s == 1 ? d[10:6] : d[5:0];
   endfunction : rx_f
   function automatic int tx_f(logic [15:0] t, int s);
      return s == 0 ? t[12:8] : s == 1 ? t[7:4] : t[3:0];
   endfunction : tx_f
   task automatic conclude();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   task automatic chk(string nm, int lo, int hi, int g);
      total_checks++;
      if (g < lo || g > hi) begin
         miscompares++;
         $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask : chk
   task automatic chkr(logic [15:0] a, logic [15:0] e);
      @(posedge core_clk) addr <= a;
      repeat (2) @(posedge core_clk);
      #1;
      total_checks++;
      if (rdat !== e) begin
         miscompares++;
         $display("Error reg %h expected %h seen %h", a, e, rdat);
      end
   endtask : chkr
   task automatic wr(logic [15:0] a, logic [15:0] d);
      @(posedge core_clk);
      we <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge core_clk) we <= 1'b0;
   endtask : wr
   // trigger bit only moves with both directions off
   task automatic cfg(logic [15:0] c);
      wr(pkt_start_pkg::CTRL_ADDR, c & 16'hfffc);
      wr(pkt_start_pkg::CTRL_ADDR, c);
   endtask : cfg
   task automatic frame(int len, int sfd_at);
      @(posedge core_clk);
      rxf.frame <= 1'b1;
      txf.frame <= 1'b1;
      repeat (sfd_at) @(posedge core_clk);
      rxf.sfd <= 1'b1;
      txf.sfd <= 1'b1;
      repeat (len - sfd_at) @(posedge core_clk);
      rxf <= '0;
      txf <= '0;
      repeat (60) @(posedge core_clk);
   endtask : frame
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      logic [15:0] d, t, f;
      int rd, td, tr, tc;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      chkr(pkt_start_pkg::CTRL_ADDR, 16'h0034);
      chkr(pkt_start_pkg::RX_DEL_ADDR, 16'h0000);
      chkr(pkt_start_pkg::TX_DEL_ADDR, 16'h0000);
      wr(16'h9430, 16'hffff);
      chkr(16'h9430, 16'h0000);
      wr(pkt_start_pkg::TX_DEL_ADDR, 16'hffff);
      chkr(pkt_start_pkg::TX_DEL_ADDR, 16'h1fff);
      wr(pkt_start_pkg::CTRL_ADDR, 16'hff84);
      chkr(pkt_start_pkg::CTRL_ADDR, 16'h0004);
      frame(200, 20);
      chk("rx off", -1, -1, rx_rise);
      chk("tx off", -1, -1, tx_rise);
      for (int s = 0; s < 3; s++) begin
         spd <= pkt_start_pkg::speed_t'(s);
         d = rnd();
         t = rnd() & 16'h1fff;
         rd = rx_f(d, s);
         td = tx_f(t, s);
         // transmit delay counts 8 ns periods, expressed here in core cycles
         tc = td * pkt_start_pkg::TICK_PS / pkt_start_pkg::CORE_CLK_PS;
         tr = s[0] ? 30 : 1;
         wr(pkt_start_pkg::RX_DEL_ADDR, d);
         chkr(pkt_start_pkg::RX_DEL_ADDR, d);
         wr(pkt_start_pkg::TX_DEL_ADDR, t);
         chkr(pkt_start_pkg::TX_DEL_ADDR, t);
         cfg(s[0] ? 16'h0037 : 16'h0033);
         frame(1200, 30);
         chk("rx rise", tr + 16 * rd - 14, tr + 16 * rd + 10, rx_rise);
         chk("tx rise", tr + tc, tr + tc + 8, tx_rise);
         chk("rx len", 1196 - rx_rise, 1208 - rx_rise, rx_len);
         chk("tx len", 1196 - tx_rise, 1208 - tx_rise, tx_len);
      end
      wr(pkt_start_pkg::RX_DEL_ADDR, 16'h0000);
      wr(pkt_start_pkg::TX_DEL_ADDR, 16'h0000);
      f = rnd() & 16'h0007;
      cfg(16'h000b | (f << 4));
      frame(2000, 10);
      chk("rx fixed", (f + 1) * 128 - 20, (f + 1) * 128 + 20, rx_len);
      chk("tx fixed", (f + 1) * 128 - 20, (f + 1) * 128 + 20, tx_len);
      cfg(16'h007b);
      frame(300, 10);
      chk("rx cut", 290, 306, rx_len);
      chk("tx cut", 290, 306, tx_len);
      conclude();
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         conclude();
      end
   end
endmodule : pkt_start_tb_top
`default_nettype wire
